// ===== common/bta_pkg.sv
// package of constants and types for the branch target address unit
package bta_pkg;

    // ****************************************
    // address space and widths
    // ****************************************
    localparam int ADDR_W = 16;
    localparam int DISP_W = 8;
    localparam int DISP_SIGN_BIT = 7;
    localparam int LEN_W = 3;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // ****************************************
    // fixed-area call region
    // ****************************************
    localparam logic [15:0] FIXED_AREA_BASE = 16'h0800;
    localparam logic [15:0] FIXED_AREA_LAST = 16'h0fff;
    localparam int SHORT_TGT_W = 11;

    // ****************************************
    // vector table
    // ****************************************
    localparam logic [15:0] VEC_TABLE_BASE = 16'h0040;
    localparam logic [15:0] VEC_TABLE_LAST = 16'h007f;
    localparam int VEC_IDX_LO = 1;
    localparam int VEC_IDX_HI = 5;
    localparam int VEC_IDX_W = 5;
    localparam int VEC_MEM_W = 6;

    // ****************************************
    // target mode selection and table lookup states
    // ****************************************
    typedef enum logic [2:0] {
        BTA_SEQ,
        BTA_REL,
        BTA_IMM16,
        BTA_IMM11,
        BTA_TABLE,
        BTA_REGPAIR
    } bta_mode_t;

    typedef enum logic [1:0] {
        BTA_IDLE,
        BTA_RD_LO,
        BTA_RD_HI
    } bta_state_t;

endpackage

// ===== rtl/bta_unit.sv
// branch target address unit: next program counter selection

module bta_unit
    import bta_pkg::*;
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // instruction from decode
    input  wire logic                   instr_valid,
    input  wire bta_mode_t              instr_mode,
    input  wire logic                   cond_taken,
    input  wire logic [LEN_W-1:0]       instr_len,
    input  wire logic [7:0]             opcode,
    input  wire logic [DISP_W-1:0]      branch_displacement,
    input  wire logic [ADDR_W-1:0]      full_target_address,
    input  wire logic [SHORT_TGT_W-1:0] short_call_target,
    input  wire logic [ADDR_W-1:0]      accumulator_pair,
    // vector table load
    input  wire logic                   vec_wr_en,
    input  wire logic [VEC_MEM_W-1:0]   vec_wr_addr,
    input  wire logic [7:0]             vec_wr_data,
    // status to fetch
    output logic                        busy,
    output logic                        pc_load,
    output logic      [ADDR_W-1:0]      program_counter
);

    // ****************************************
    // state and helpers
    // ****************************************
    typedef struct packed {
        bta_state_t        st;
        logic [ADDR_W-1:0] pc;
        logic [7:0]        lo;
        logic              ld;
    } bta_regs_t;

    bta_regs_t r_q, r_d;
    logic [VEC_MEM_W-1:0] mem_addr;
    logic                 mem_rd;
    logic [7:0]           mem_data;
    logic [ADDR_W-1:0]    next_seq;
    logic [ADDR_W-1:0]    tbl_entry;

    // wraps modulo 16 bits on purpose
    function automatic logic [ADDR_W-1:0] add16(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] b
    );
        add16 = ADDR_W'(a + b);
    endfunction

    function automatic logic [ADDR_W-1:0] sext8(input logic [DISP_W-1:0] d);
        sext8 = {{(ADDR_W-DISP_W){d[DISP_SIGN_BIT]}}, d};
    endfunction

    assign next_seq  = add16(r_q.pc, {{(ADDR_W-LEN_W){1'b0}}, instr_len});
    // index from opcode bits 1..5, doubled by keeping bit 0 clear
    assign tbl_entry = VEC_TABLE_BASE | {10'h000, opcode[VEC_IDX_HI:VEC_IDX_LO], 1'b0};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        r_d      = r_q;
        r_d.ld   = 1'b0;
        mem_rd   = 1'b0;
        mem_addr = tbl_entry[VEC_MEM_W-1:0];
        case (r_q.st)
            BTA_IDLE: begin
                if (instr_valid) begin
                    r_d.ld = 1'b1;
                    case (instr_mode)
                        BTA_SEQ: begin
                            r_d.pc = next_seq;
                        end
                        BTA_REL: begin
                            // untaken conditionals fall through
                            r_d.pc = cond_taken ? add16(next_seq, sext8(branch_displacement)) : next_seq;
                        end
                        BTA_IMM16: begin
                            r_d.pc = full_target_address;
                        end
                        BTA_IMM11: begin
                            // base bit alone sets the region, the 11 bits fill the rest
                            r_d.pc = FIXED_AREA_BASE | {5'h00, short_call_target};
                        end
                        BTA_TABLE: begin
                            r_d.ld = 1'b0;
                            mem_rd = 1'b1;
                            r_d.st = BTA_RD_LO;
                        end
                        BTA_REGPAIR: begin
                            r_d.pc = accumulator_pair;
                        end
                        default: begin
                            // unused mode codes load nothing
                            r_d.ld = 1'b0;
                        end
                    endcase
                end
            end
            BTA_RD_LO: begin
                // low byte arrives now; fetch the odd byte next
                r_d.lo   = mem_data;
                mem_rd   = 1'b1;
                mem_addr = r_q.pc[VEC_MEM_W-1:0];
                r_d.st   = BTA_RD_HI;
            end
            BTA_RD_HI: begin
                r_d.pc = {mem_data, r_q.lo};
                r_d.ld = 1'b1;
                r_d.st = BTA_IDLE;
            end
            default: r_d.st = BTA_IDLE;
        endcase
        // park odd entry address in pc while waiting
        if (r_q.st == BTA_IDLE && instr_valid && instr_mode == BTA_TABLE) begin
            r_d.pc = tbl_entry | 16'h0001;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r_q <= '{st: BTA_IDLE, pc: PC_RESET, lo: 8'h00, ld: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************
    // vector memory
    // ****************************************
    // registered read costs a cycle per byte, hence the two busy cycles
    bta_vec_mem u_mem (
        .clk     (clk),
        .wr_en   (vec_wr_en),
        .wr_addr (vec_wr_addr),
        .wr_data (vec_wr_data),
        .rd_en   (mem_rd),
        .rd_addr (mem_addr),
        .rd_data (mem_data)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign busy            = (r_q.st != BTA_IDLE);
    assign pc_load         = r_q.ld;
    assign program_counter = r_q.pc;

    // ****************************************
    // checking helpers
    // ****************************************
    // an instruction is taken only while the unit is idle
    logic take;

    assign take = !busy && instr_valid;

    // ****************************************
    // assertions: sequential and relative
    // ****************************************
    a_seq_advance: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_SEQ) |=> program_counter == $past(next_seq))
        else $error("sequential advance wrong");
    a_seq_load: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_SEQ) |=> pc_load && !busy)
        else $error("sequential load missing");
    a_pc_hold: assert property (@(posedge clk) disable iff (!nrst)
        (!busy && !instr_valid) |=> !pc_load && $stable(program_counter))
        else $error("program counter moved while idle");
    a_rel_target: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REL && cond_taken)
        |=> program_counter == 16'($past(next_seq) + {{8{$past(branch_displacement[7])}}, $past(branch_displacement)}))
        else $error("relative target wrong");
    a_rel_reach: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REL && cond_taken && branch_displacement == 8'h80)
        |=> program_counter == 16'($past(next_seq) - 16'h0080))
        else $error("negative reach wrong");
    a_rel_fwd: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REL && cond_taken && branch_displacement == 8'h7f)
        |=> program_counter == 16'($past(next_seq) + 16'h007f))
        else $error("positive reach wrong");
    a_sign_ext: assert property (@(posedge clk) disable iff (!nrst)
        $signed(sext8(branch_displacement)) == $signed(branch_displacement))
        else $error("sign extension wrong");
    a_rel_untaken: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REL && !cond_taken) |=> program_counter == $past(next_seq))
        else $error("untaken branch moved");
    a_rel_load: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REL) |=> pc_load && !busy)
        else $error("branch load missing");
    a_wrap_add: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REL && cond_taken)
        |=> 16'(program_counter - $past(next_seq)) == 16'($signed($past(branch_displacement))))
        else $error("address wrap wrong");

    // ****************************************
    // assertions: immediate and register pair
    // ****************************************
    a_imm16_load: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_IMM16) |=> pc_load && program_counter == $past(full_target_address))
        else $error("long target wrong");
    a_fixed_area: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_IMM11)
        |=> program_counter >= FIXED_AREA_BASE && program_counter <= FIXED_AREA_LAST)
        else $error("fixed-area target out of range");
    a_fixed_low: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_IMM11) |=> program_counter[SHORT_TGT_W-1:0] == $past(short_call_target))
        else $error("fixed-area low bits wrong");
    a_fixed_load: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_IMM11) |=> pc_load)
        else $error("fixed-area load missing");
    a_regpair: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REGPAIR) |=> program_counter == $past(accumulator_pair))
        else $error("register-pair target wrong");
    a_regpair_load: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_REGPAIR) |=> pc_load)
        else $error("register-pair load missing");

    // ****************************************
    // assertions: table call
    // ****************************************
    a_table_load: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_TABLE) |=> busy ##1 busy ##1 (!busy && pc_load))
        else $error("table call timing wrong");
    a_tbl_even_rd: assert property (@(posedge clk) disable iff (!nrst)
        (take && instr_mode == BTA_TABLE)
        |-> mem_rd && !mem_addr[0] && mem_addr[VEC_MEM_W-1:1] == opcode[VEC_IDX_HI:VEC_IDX_LO])
        else $error("table low byte address wrong");
    a_tbl_odd_rd: assert property (@(posedge clk) disable iff (!nrst)
        (r_q.st == BTA_RD_LO)
        |-> mem_rd && mem_addr[0] && mem_addr[VEC_MEM_W-1:1] == r_q.pc[VEC_MEM_W-1:1])
        else $error("table high byte address wrong");
    a_table_range: assert property (@(posedge clk) disable iff (!nrst)
        (r_q.st == BTA_RD_LO) |-> r_q.pc >= VEC_TABLE_BASE && r_q.pc <= VEC_TABLE_LAST && r_q.pc[0])
        else $error("vector entry address wrong");
    a_table_hold: assert property (@(posedge clk) disable iff (!nrst)
        (r_q.st == BTA_RD_LO) |=> r_q.st == BTA_RD_HI)
        else $error("table lookup skipped a byte");
    a_busy_no_load: assert property (@(posedge clk) disable iff (!nrst)
        busy |-> !pc_load)
        else $error("load during lookup");
    a_table_done: assert property (@(posedge clk) disable iff (!nrst)
        (r_q.st == BTA_RD_HI) |=> !busy && pc_load)
        else $error("table call did not finish");
    a_busy_ignore: assert property (@(posedge clk) disable iff (!nrst)
        (r_q.st == BTA_RD_LO && instr_valid) |=> busy && !pc_load)
        else $error("request taken while busy");

    // ****************************************
    // covers
    // ****************************************
    c_rel_back: cover property (@(posedge clk) disable iff (!nrst)
        take && instr_mode == BTA_REL && cond_taken && branch_displacement[7]);
    c_table: cover property (@(posedge clk) disable iff (!nrst) r_q.st == BTA_RD_HI);
    c_fixed_area_call: cover property (@(posedge clk) disable iff (!nrst) take && instr_mode == BTA_IMM11);
    c_refused: cover property (@(posedge clk) disable iff (!nrst) busy && instr_valid);
    c_regpair: cover property (@(posedge clk) disable iff (!nrst) take && instr_mode == BTA_REGPAIR);

endmodule

// ===== rtl/bta_vec_mem.sv
// small vector table memory with registered read data
module bta_vec_mem
    import bta_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // write port
    input  wire logic                 wr_en,
    input  wire logic [VEC_MEM_W-1:0] wr_addr,
    input  wire logic [7:0]           wr_data,
    // read port
    input  wire logic                 rd_en,
    input  wire logic [VEC_MEM_W-1:0] rd_addr,
    output logic      [7:0]           rd_data
);

    logic [7:0] mem [0:(1<<VEC_MEM_W)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// ===== sim/bta_fetch_model.sv
// far-side model: decode logic loading the vector table
module bta_fetch_model
    import bta_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // vector table write port
    output logic                      vec_wr_en,
    output logic      [VEC_MEM_W-1:0] vec_wr_addr,
    output logic      [7:0]           vec_wr_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        vec_wr_en   = 1'b0;
        vec_wr_addr = 6'h00;
        vec_wr_data = 8'h00;
    end

    // ****************************************
    // table entry load, slot = byte address 40h..7fh less base
    // ****************************************
    task automatic put_entry(input logic [4:0] idx, input logic [15:0] tgt);
        @(posedge clk);
        vec_wr_en   <= 1'b1;
        vec_wr_addr <= {idx, 1'b0};
        vec_wr_data <= tgt[7:0];
        @(posedge clk);
        vec_wr_addr <= {idx, 1'b1};
        vec_wr_data <= tgt[15:8];
        @(posedge clk);
        vec_wr_en   <= 1'b0;
        // released bus must not keep the last byte
        vec_wr_data <= ~tgt[15:8];
    endtask
endmodule

// ===== sim/test_branch_target_address_unit.sv
// self-checking bench for the branch target address unit
module test_branch_target_address_unit import bta_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, nrst, instr_valid, cond_taken, vec_wr_en, busy, pc_load;
    bta_mode_t   instr_mode;
    logic [2:0]  instr_len;
    logic [7:0]  opcode, branch_displacement, vec_wr_data, dv [5];
    logic [15:0] full_target_address, accumulator_pair, program_counter, pc_m;
    logic [10:0] short_call_target;
    logic [5:0]  vec_wr_addr;
    int          mismatches, compares;

    bta_unit dut_u (.clk, .nrst, .instr_valid, .instr_mode, .cond_taken, .instr_len, .opcode,
        .branch_displacement, .full_target_address, .short_call_target, .accumulator_pair,
        .vec_wr_en, .vec_wr_addr, .vec_wr_data, .busy, .pc_load, .program_counter);
    bta_fetch_model part_u (.clk, .vec_wr_en, .vec_wr_addr, .vec_wr_data);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************
    // compare and verdict
    // ****************************************
    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // one instruction: present one cycle (two for a table call), then judge the load at its fixed latency
    task automatic issue(input bta_mode_t m, input logic [2:0] len, input logic ct, input logic [7:0] d,
                         input logic [15:0] f, input logic [10:0] s, input logic [15:0] a,
                         input logic [7:0] op, input logic [15:0] e);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_mode  <= m;
        {instr_len, cond_taken, branch_displacement, opcode} <= {len, ct, d, op};
        {full_target_address, short_call_target, accumulator_pair} <= {f, s, a};
        @(posedge clk);
        // table call keeps valid up a cycle: must be ignored while busy
        instr_valid <= (m == BTA_TABLE);
        if (m == BTA_TABLE) begin
            #1 chk1("busy", 1'b1, busy);
            @(posedge clk);
            instr_valid <= 1'b0;
            #1 chk1("busy", 1'b1, busy);
            @(posedge clk);
        end
        #1 chk1("pc_load", 1'b1, pc_load);
        chk16("program_counter", e, program_counter);
        chk1("busy", 1'b0, busy);
        pc_m = e;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_seq();
        for (int l = 1; l <= 4; l++) issue(BTA_SEQ, 3'(l), 1'b1, 8'h7f, 16'h9999, 11'h0, 16'h0, 8'h0, pc_m + 16'(l));
        issue(BTA_REL, 3'h2, 1'b0, 8'h40, 16'h0, 11'h0, 16'h0, 8'h0, pc_m + 16'h2);
    endtask
    task automatic test_rel();
        dv = '{8'h7f, 8'h80, 8'h00, 8'hff, 8'h05};
        foreach (dv[i]) issue(BTA_REL, 3'h2, 1'b1, dv[i], 16'h0, 11'h0, 16'h0, 8'h0,
                              pc_m + 16'h2 + {{8{dv[i][7]}}, dv[i]});
        issue(BTA_IMM16, 3'h3, 1'b1, 8'h0, 16'hfff0, 11'h0, 16'h0, 8'h0, 16'hfff0);
        issue(BTA_REL, 3'h2, 1'b1, 8'h7f, 16'h0, 11'h0, 16'h0, 8'h0, 16'h0071);
        issue(BTA_REL, 3'h2, 1'b1, 8'h80, 16'h0, 11'h0, 16'h0, 8'h0, 16'hfff3);
    endtask
    task automatic test_imm();
        issue(BTA_IMM16, 3'h3, 1'b1, 8'h0, 16'h1234, 11'h7ff, 16'h0, 8'h0, 16'h1234);
        issue(BTA_IMM16, 3'h3, 1'b1, 8'h0, 16'hffff, 11'h0, 16'h0, 8'h0, 16'hffff);
        issue(BTA_IMM11, 3'h2, 1'b1, 8'h0, 16'hffff, 11'h7ff, 16'h0, 8'h0, 16'h0fff);
        issue(BTA_IMM11, 3'h2, 1'b1, 8'h0, 16'hffff, 11'h000, 16'h0, 8'h0, 16'h0800);
        issue(BTA_IMM11, 3'h2, 1'b1, 8'h0, 16'h0, 11'h555, 16'h0, 8'h0, 16'h0d55);
        issue(BTA_REGPAIR, 3'h2, 1'b1, 8'h0, 16'h1111, 11'h0, 16'hbeef, 8'h0, 16'hbeef);
    endtask
    task automatic test_table();
        part_u.put_entry(5'd0, 16'h1357);
        part_u.put_entry(5'd31, 16'hfedc);
        part_u.put_entry(5'd10, 16'h2468);
        issue(BTA_TABLE, 3'h1, 1'b1, 8'h0, 16'h0, 11'h0, 16'h0, {2'b11, 5'd31, 1'b1}, 16'hfedc);
        issue(BTA_TABLE, 3'h1, 1'b1, 8'h0, 16'h0, 11'h0, 16'h0, {2'b11, 5'd0, 1'b1}, 16'h1357);
        issue(BTA_TABLE, 3'h1, 1'b1, 8'h0, 16'h0, 11'h0, 16'h0, {2'b00, 5'd10, 1'b0}, 16'h2468);
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        {nrst, instr_valid, cond_taken, instr_len, opcode, branch_displacement} = '0;
        {full_target_address, short_call_target, accumulator_pair} = '0;
        instr_mode = BTA_SEQ;
        mismatches = 0;
        compares = 0;
        pc_m = PC_RESET;
        repeat (20) @(posedge clk);
        chk16("program_counter", PC_RESET, program_counter);
        chk1("pc_load", 1'b0, pc_load);
        nrst <= 1'b1;
        test_seq();
        test_rel();
        test_imm();
        test_table();
        report_and_stop();
    end
endmodule
